// ==== inc/lsc_pkg.sv ====
// shared constants and types for the lcd scan controller
package lsc_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ROWB    = 8'h04;
  localparam logic [7:0] OFF_TOTAL   = 8'h08;
  localparam logic [7:0] OFF_PITCH   = 8'h0c;
  localparam logic [7:0] OFF_LINES   = 8'h10;
  localparam logic [7:0] OFF_SCROLL_START_ADDRESS_1    = 8'h14;
  localparam logic [7:0] OFF_SADLO   = 8'h18;
  localparam logic [7:0] OFF_CGBASE  = 8'h1c;
  localparam logic [7:0] OFF_CURSOR  = 8'h20;
  localparam logic [7:0] OFF_STEP    = 8'h24;
  localparam logic [7:0] OFF_HDOT    = 8'h28;
  localparam logic [7:0] OFF_CUR_LO  = 8'h2c;
  localparam logic [7:0] OFF_CUR_HI  = 8'h30;
  localparam logic [7:0] OFF_MEMW    = 8'h34;
  localparam logic [7:0] OFF_MEMR    = 8'h38;
  localparam logic [7:0] OFF_STATUS  = 8'h3c;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ROWB_RST    = 8'h27;
  localparam logic [7:0]  TOTAL_RST   = 8'h2b;
  localparam logic [15:0] PITCH_RST   = 16'h0028;
  localparam logic [7:0]  LINES_RST   = 8'hef;
  localparam logic [15:0] STEP_RST    = 16'h0001;
  localparam logic [15:0] CUR_HI_RST  = 16'hffff;
  localparam logic [3:0]  PH_LAST     = 4'h8;
  localparam logic [3:0]  PH_CODE     = 4'h2;
  localparam logic [3:0]  PH_CG       = 4'h3;
  localparam logic [3:0]  PH_PIX      = 4'h5;
  localparam logic [3:0]  ROW_LAST_SH = 4'h7;
  localparam logic [3:0]  ROW_LAST_TL = 4'hf;
  localparam logic [15:0] EXT_CG_BASE = 16'hf000;
  localparam logic [2:0]  CGRAM1_TOP  = 3'h4;
  localparam logic [2:0]  CGRAM2_TOP  = 3'h7;
  localparam int          CTRL_W      = 10;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LSC_IDLE  = 2'b00,
    LSC_FETCH = 2'b01,
    LSC_PAUSE = 2'b11
  } lsc_state_t;

  typedef struct packed {
    logic block_shape;
    logic gfx_on;
    logic text_on;
    logic three_layers;
    logic external_cg_select;
    logic cgram_bit6_correction;
    logic tall_font_select;
    logic two_panel;
    logic graphics_mode;
    logic enable;
  } lsc_ctrl_t;

  typedef struct packed {
    logic [7:0] line;
    logic [3:0] row;
    logic       pause;
    logic       panel;
    logic       host_set;
    logic       pending;
  } lsc_status_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lsc_mem_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] pixels;
    logic       cursor;
    logic       block;
  } lsc_pix_t;

endpackage

// ==== design/lsc_scan.sv ====
// display refresh scanner with cursor and character generator mapping
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - scan each line left to right up to row byte count, lines top down
// - graphics: each line starts at previous line start plus pitch
// - text: same start per bitmap row, next row; then start plus pitch
// - two-panel: upper line n then lower line b+n, alternating per line
// - every display memory read cycle lasts nine clocks
// - row byte count plus one read cycles per line
// - pause reads for total minus row byte count cycles, drive continues
// - two-panel: line latch pulse only after the lower screen line
// - cursor register is both cursor position and host access address
// - after each host access cursor steps by the programmed step
// - cursor on first or third layer only, hidden outside layer memory
// - graphics-only dummy cursor only when host set the cursor address
// - no text: bar cursor; mixed layer with block: block over text only
// - text scrolls by characters, graphics by pixels; one shared h-shift
// - horizontal pixel scroll through the dot-scroll register
// - external generator rom at f000-f7ff short, f000-ffff tall fonts
// - font select clear gives 8-row cells, set gives 16-row cells
// - code value and external select bit pick internal rom or external generator
// - 8-bit codes; generator ram banks switch via generator base
// - bit6 option forces bit 6 of generator ram codes to zero
// - generator address is base plus shifted code plus bitmap row
module lsc_scan (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output lsc_pkg::lsc_mem_req_t      mem_req,
  input  wire logic [7:0]            mem_rdata,
  output logic      [11:0]           int_rom_addr,
  input  wire logic [7:0]            int_rom_data,
  output lsc_pkg::lsc_pix_t          pix,
  output logic                       line_latch_pulse,
  output logic                       scan_pause,
  output logic      [2:0]            hdot_shift,
  output logic      [1:0]            cursor_layer
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  lsc_pkg::lsc_ctrl_t    ctrl_r;
  lsc_pkg::lsc_state_t   st_r, st_nxt;
  lsc_pkg::lsc_mem_req_t req_nxt;
  lsc_pkg::lsc_pix_t     pix_nxt;
  lsc_pkg::lsc_status_t  status;
  logic [7:0]  rowb_r, total_r, lines_r, wbuf_r, rbuf_r, code_r;
  logic [15:0] pitch_r, scroll_start_address_1_r, sadlo_r, cg_base_r, step_r;
  logic [15:0] cursor_r, cur_lo_r, cur_hi_r, cursor_nxt;
  logic [15:0] up_start_r, lo_start_r, scan_addr_r, fetch_addr_r;
  logic [2:0]  hdot_r;
  logic [3:0]  ph_r, row_r;
  logic [7:0]  cyc_r, line_r;
  logic        panel_r, pend_r, pend_wr_r, host_set_r, hrd_r, lp_r;
  logic [8:0]  fcnt_r;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire acc      = psel && penable;
  wire h_ctrl   = paddr == lsc_pkg::OFF_CTRL;
  wire h_rowb   = paddr == lsc_pkg::OFF_ROWB;
  wire h_total  = paddr == lsc_pkg::OFF_TOTAL;
  wire h_pitch  = paddr == lsc_pkg::OFF_PITCH;
  wire h_lines  = paddr == lsc_pkg::OFF_LINES;
  wire h_scroll_start_address_1   = paddr == lsc_pkg::OFF_SCROLL_START_ADDRESS_1;
  wire h_sadlo  = paddr == lsc_pkg::OFF_SADLO;
  wire h_cgbase = paddr == lsc_pkg::OFF_CGBASE;
  wire h_cursor = paddr == lsc_pkg::OFF_CURSOR;
  wire h_step   = paddr == lsc_pkg::OFF_STEP;
  wire h_hdot   = paddr == lsc_pkg::OFF_HDOT;
  wire h_cur_lo = paddr == lsc_pkg::OFF_CUR_LO;
  wire h_cur_hi = paddr == lsc_pkg::OFF_CUR_HI;
  wire h_memw   = paddr == lsc_pkg::OFF_MEMW;
  wire h_memr   = paddr == lsc_pkg::OFF_MEMR;
  wire h_status = paddr == lsc_pkg::OFF_STATUS;
  wire mapped   = h_ctrl | h_rowb | h_total | h_pitch | h_lines | h_scroll_start_address_1 |
                  h_sadlo | h_cgbase | h_cursor | h_step | h_hdot |
                  h_cur_lo | h_cur_hi | h_memw | h_memr | h_status;
  // a second memory request while one waits for the pause is refused
  wire busy_err = pwrite && pend_r && (h_memw || h_memr);
  wire err      = acc && (!mapped || busy_err);
  wire wr       = acc && pwrite && !err;
  wire host_req = wr && (h_memw || h_memr);

  assign pready  = 1'b1;
  assign pslverr = err;
  assign status  = '{line: line_r, row: row_r, pause: st_r == lsc_pkg::LSC_PAUSE,
                     panel: panel_r, host_set: host_set_r, pending: pend_r};
  assign prdata  = !psel ? 32'h0 :
                   h_ctrl   ? {22'h0, ctrl_r} :
                   h_rowb   ? {24'h0, rowb_r} :
                   h_total  ? {24'h0, total_r} :
                   h_pitch  ? {16'h0, pitch_r} :
                   h_lines  ? {24'h0, lines_r} :
                   h_scroll_start_address_1   ? {16'h0, scroll_start_address_1_r} :
                   h_sadlo  ? {16'h0, sadlo_r} :
                   h_cgbase ? {16'h0, cg_base_r} :
                   h_cursor ? {16'h0, cursor_r} :
                   h_step   ? {16'h0, step_r} :
                   h_hdot   ? {29'h0, hdot_r} :
                   h_cur_lo ? {16'h0, cur_lo_r} :
                   h_cur_hi ? {16'h0, cur_hi_r} :
                   h_memw   ? {24'h0, wbuf_r} :
                   h_memr   ? {24'h0, rbuf_r} :
                   h_status ? {16'h0, status} : 32'h0;

  // ----------------------------------------------------------------------
  // line and frame sequencing
  // ----------------------------------------------------------------------
  wire run      = ctrl_r.enable;
  wire fetching = st_r == lsc_pkg::LSC_FETCH;
  wire ph_end   = ph_r == lsc_pkg::PH_LAST;
  wire line_end = ph_end && cyc_r == total_r &&
                  st_r != lsc_pkg::LSC_IDLE;
  wire upper    = ctrl_r.two_panel && !panel_r;
  wire [3:0] row_last = ctrl_r.tall_font_select ?
                        lsc_pkg::ROW_LAST_TL : lsc_pkg::ROW_LAST_SH;
  wire row_wrap  = ctrl_r.graphics_mode || row_r == row_last;
  wire frame_end = line_r == lines_r;
  // new frame restarts at the scroll starts, else text holds its start until its last bitmap row
  wire [15:0] up_adv = frame_end ? scroll_start_address_1_r :
                       row_wrap ? up_start_r + pitch_r : up_start_r;
  wire [15:0] lo_adv = frame_end ? sadlo_r :
                       row_wrap ? lo_start_r + pitch_r : lo_start_r;
  wire [3:0]  row_adv  = (row_wrap || frame_end) ? 4'h0 : row_r + 4'h1;
  wire [7:0]  line_adv = frame_end ? 8'h0 : line_r + 8'h1;
  wire [15:0] scan_nxt = !run ? scroll_start_address_1_r :
                         line_end ? (upper ? lo_start_r : up_adv) :
                         (ph_end && fetching) ? scan_addr_r + 16'h1 :
                         scan_addr_r;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      lsc_pkg::LSC_IDLE:  st_nxt = lsc_pkg::LSC_FETCH;
      lsc_pkg::LSC_FETCH:
        if (line_end)
          st_nxt = lsc_pkg::LSC_FETCH;
        else if (ph_end && cyc_r == rowb_r)
          st_nxt = lsc_pkg::LSC_PAUSE;
      lsc_pkg::LSC_PAUSE:
        if (line_end)
          st_nxt = lsc_pkg::LSC_FETCH;
      default: st_nxt = lsc_pkg::LSC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      st_r    <= lsc_pkg::LSC_IDLE;
      ph_r    <= 4'h0;
      cyc_r   <= 8'h0;
      line_r  <= 8'h0;
      row_r   <= 4'h0;
      panel_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      // idle holds phase 0 so the first fetch cycle starts with its read
      ph_r <= (ph_end || st_r == lsc_pkg::LSC_IDLE) ? 4'h0 :
              ph_r + 4'h1;
      if (ph_end)
        cyc_r <= line_end ? 8'h0 : cyc_r + 8'h1;
      if (line_end)
        panel_r <= upper;
      if (line_end && !upper)
      begin
        row_r  <= row_adv;
        line_r <= line_adv;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      up_start_r  <= 16'h0;
      lo_start_r  <= 16'h0;
      scan_addr_r <= 16'h0;
    end
    else
    begin
      scan_addr_r <= scan_nxt;
      if (!run)
      begin
        up_start_r <= scroll_start_address_1_r;
        lo_start_r <= sadlo_r;
      end
      else if (line_end && !upper)
      begin
        up_start_r <= up_adv;
        lo_start_r <= lo_adv;
      end
    end
  end

  // ----------------------------------------------------------------------
  // character generator mapping
  // ----------------------------------------------------------------------
  // codes 80-9f and e0-ff belong to generator ram, others to a rom
  wire is_cgram  = code_r[7:5] == lsc_pkg::CGRAM1_TOP ||
                   code_r[7:5] == lsc_pkg::CGRAM2_TOP;
  wire use_int   = !is_cgram && !ctrl_r.external_cg_select;
  wire [7:0] code_eff = (is_cgram && ctrl_r.cgram_bit6_correction) ?
                        (code_r & 8'hbf) : code_r;
  wire [15:0] code_sh = ctrl_r.tall_font_select ?
                        {4'h0, code_eff, 4'h0} : {5'h0, code_eff, 3'h0};
  wire [15:0] cg_base = is_cgram ? cg_base_r : lsc_pkg::EXT_CG_BASE;
  wire [15:0] cg_addr = cg_base + code_sh + {12'h0, row_r};
  assign int_rom_addr = {code_r, row_r};

  // ----------------------------------------------------------------------
  // memory port: scan fetch, generator fetch, host access in pause
  // ----------------------------------------------------------------------
  wire scan_rd = fetching && ph_r == 4'h0;
  wire cg_rd   = fetching && ph_r == lsc_pkg::PH_CG &&
                 !ctrl_r.graphics_mode && !use_int;
  wire host_op = st_r == lsc_pkg::LSC_PAUSE && ph_r == 4'h0 && pend_r;
  assign req_nxt = '{rd: scan_rd || cg_rd || (host_op && !pend_wr_r),
                     wr: host_op && pend_wr_r,
                     addr: host_op ? cursor_r :
                           cg_rd ? cg_addr : scan_addr_r,
                     wdata: wbuf_r};
  // software write to the cursor beats the auto-step in the same cycle
  assign cursor_nxt = (wr && h_cursor) ? pwdata[15:0] :
                      host_op ? cursor_r + step_r : cursor_r;

  // ----------------------------------------------------------------------
  // cursor and pixel output
  // ----------------------------------------------------------------------
  wire in_layer = cursor_r >= cur_lo_r && cursor_r <= cur_hi_r;
  wire cur_ok   = ctrl_r.text_on ||
                  (ctrl_r.gfx_on && host_set_r);
  wire block    = ctrl_r.block_shape && ctrl_r.text_on &&
                  !ctrl_r.graphics_mode;
  assign pix_nxt = '{valid: fetching && ph_r == lsc_pkg::PH_PIX,
                     pixels: ctrl_r.graphics_mode ? code_r :
                             use_int ? int_rom_data : mem_rdata,
                     cursor: in_layer && cur_ok &&
                             fetch_addr_r == cursor_r,
                     block: block};
  assign cursor_layer = ctrl_r.three_layers ? 2'h3 : 2'h1;
  assign scan_pause   = st_r == lsc_pkg::LSC_PAUSE;
  assign hdot_shift   = hdot_r;
  assign line_latch_pulse = lp_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_req      <= '0;
      pix          <= '0;
      code_r       <= 8'h0;
      fetch_addr_r <= 16'h0;
      lp_r         <= 1'b0;
      fcnt_r       <= 9'h0;
    end
    else
    begin
      mem_req <= req_nxt;
      pix     <= pix_nxt;
      lp_r    <= run && line_end && !upper;
      fcnt_r  <= line_end ? 9'h0 : fcnt_r + {8'h0, scan_rd};
      if (scan_rd)
        fetch_addr_r <= scan_addr_r;
      if (fetching && ph_r == lsc_pkg::PH_CODE)
        code_r <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= '0;      rowb_r  <= lsc_pkg::ROWB_RST;
      total_r <= lsc_pkg::TOTAL_RST;  pitch_r <= lsc_pkg::PITCH_RST;
      lines_r <= lsc_pkg::LINES_RST;  scroll_start_address_1_r <= 16'h0;  sadlo_r <= 16'h0;
      cg_base_r <= 16'h0;  step_r <= lsc_pkg::STEP_RST;  hdot_r <= 3'h0;
      cur_lo_r <= 16'h0;   cur_hi_r <= lsc_pkg::CUR_HI_RST;
      cursor_r <= 16'h0;   wbuf_r <= 8'h0;  rbuf_r <= 8'h0;
      pend_r <= 1'b0;  pend_wr_r <= 1'b0;  host_set_r <= 1'b0;  hrd_r <= 1'b0;
    end
    else
    begin
      cursor_r <= cursor_nxt;
      if (wr && h_ctrl)   ctrl_r <= lsc_pkg::lsc_ctrl_t'(pwdata[lsc_pkg::CTRL_W-1:0]);
      if (wr && h_rowb)   rowb_r <= pwdata[7:0];
      if (wr && h_total)  total_r <= pwdata[7:0];
      if (wr && h_pitch)  pitch_r <= pwdata[15:0];
      if (wr && h_lines)  lines_r <= pwdata[7:0];
      if (wr && h_scroll_start_address_1)   scroll_start_address_1_r <= pwdata[15:0];
      if (wr && h_sadlo)  sadlo_r <= pwdata[15:0];
      if (wr && h_cgbase) cg_base_r <= pwdata[15:0];
      if (wr && h_step)   step_r <= pwdata[15:0];
      if (wr && h_hdot)   hdot_r <= pwdata[2:0];
      if (wr && h_cur_lo) cur_lo_r <= pwdata[15:0];
      if (wr && h_cur_hi) cur_hi_r <= pwdata[15:0];
      if (wr && h_memw)   wbuf_r <= pwdata[7:0];
      if (host_req)       pend_wr_r <= h_memw;
      pend_r     <= host_req || (pend_r && !host_op);
      host_set_r <= (wr && h_cursor) || (host_set_r && !host_op);
      hrd_r      <= (host_op && !pend_wr_r) ||
                    (hrd_r && ph_r != lsc_pkg::PH_CODE);
      if (hrd_r && ph_r == lsc_pkg::PH_CODE)
        rbuf_r <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !run);

  sequence s_nine;
    (ph_r != 4'h0) [*8] ##1 (ph_r == 4'h0);
  endsequence
  chk_read_cycle_len: assert property (
    (st_r != lsc_pkg::LSC_IDLE && ph_r == 4'h0) |=> s_nine)
    else $error("read cycle not nine clocks");
  chk_fetch_per_line: assert property (
    (line_end && rowb_r <= total_r) |-> fcnt_r == {1'b0, rowb_r} + 9'h1)
    else $error("wrong read count per line");
  chk_pause_no_scan: assert property (
    (scan_pause && !host_op) |=> !mem_req.rd && !mem_req.wr)
    else $error("memory read during line pause");
  chk_lp_lower_only: assert property (
    (line_end && upper) |=> !line_latch_pulse)
    else $error("latch pulse after upper panel line");
  chk_cursor_step_op: assert property (
    (host_op && !(wr && h_cursor)) |=>
      cursor_r == $past(cursor_r) + $past(step_r))
    else $error("cursor did not step after access");
  chk_host_addr_use: assert property (
    host_op |=> mem_req.addr == $past(cursor_r) &&
                (mem_req.rd || mem_req.wr))
    else $error("host access not at cursor");
  chk_gfx_line_pitch: assert property (
    (line_end && !upper && ctrl_r.graphics_mode && !frame_end) |=>
      up_start_r == $past(up_start_r) + $past(pitch_r))
    else $error("graphics line start not advanced by pitch");
  chk_text_row_hold: assert property (
    (line_end && !upper && !row_wrap && !frame_end) |=>
      $stable(up_start_r) && row_r == $past(row_r) + 4'h1)
    else $error("text row start not held");
  chk_frame_reload: assert property (
    (line_end && !upper && frame_end) |=>
      up_start_r == $past(scroll_start_address_1_r) && row_r == 4'h0 ##1 ph_r == 4'h1)
    else $error("frame start not reloaded");
  chk_ext_cg_window: assert property (
    (cg_rd && !is_cgram) |=> mem_req.addr[15:12] == 4'hf &&
      (ctrl_r.tall_font_select || mem_req.addr[11] == 1'b0))
    else $error("external generator address out of window");

endmodule // lsc_scan

// ==== testbench/lsc_mem_model.sv ====
// display memory and internal font rom model for the scan bench
`timescale 1ns/10ps
module lsc_mem_model (
  input  wire logic                  clk,
  input  wire lsc_pkg::lsc_mem_req_t req,
  output logic      [7:0]            rdata,
  input  wire logic [11:0]           rom_addr,
  output logic      [7:0]            rom_data
);
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i ^ (i >> 8));
    rdata = 8'h00;
  end
  // data valid only the cycle after a read, scrambled otherwise
  always @(posedge clk)
  begin
    if (req.wr)
      mem[req.addr] <= req.wdata;
    rdata <= req.rd ? mem[req.addr] : ~rdata;
  end
  assign rom_data = rom_addr[7:0] ^ 8'h5a;
endmodule // lsc_mem_model

// ==== testbench/lsc_scan_tb.sv ====
// self-checking bench for the lcd scan controller
`timescale 1ns/10ps
module lsc_scan_tb;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, lp, pause, err, mon = 1'b0;
  logic [7:0]  mrd, romd;
  logic [11:0] roma;
  logic [2:0]  hdot, h;
  logic [1:0]  layer;
  logic [15:0] last_a;
  lsc_pkg::lsc_mem_req_t mreq;
  lsc_pkg::lsc_pix_t     pix;
  int bad_count = 0, cmp_count = 0;
  int rowb, total, pitch, idx = 0, line = 0, gap = 0, plen = 0;
  int lps = 0, lnum = 0;
  logic [7:0]  roff [5] = '{8'h04, 8'h08, 8'h0c, 8'h24, 8'h30};
  logic [31:0] rexp [5] = '{32'h27, 32'h2b, 32'h28, 32'h1, 32'hffff};

  always #2 clk = ~clk;

  lsc_scan DUT (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mreq), .mem_rdata(mrd),
    .int_rom_addr(roma), .int_rom_data(romd), .pix(pix),
    .line_latch_pulse(lp), .scan_pause(pause), .hdot_shift(hdot),
    .cursor_layer(layer));
  lsc_mem_model mm (.clk(clk), .req(mreq), .rdata(mrd), .rom_addr(roma),
    .rom_data(romd));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, lsc_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 100);
    check(rd[0], 1'b0);
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // scan follower
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    gap++;
    if (mon && pause)
      plen++;
    else if (plen != 0)
    begin
      check(plen, 9 * (total - rowb));
      plen = 0;
    end
    if (mon && lp)
      lps++;
    if (mon && mreq.rd && !pause)
    begin
      if (idx == 0)
      begin
        check(lps, lnum != 0);
        lps = 0;
        lnum++;
      end
      check(mreq.addr, 16'h0100 + line * pitch + idx);
      if (idx != 0)
        check(gap, 9);
      gap = 0;
      last_a = mreq.addr;
      idx++;
      if (idx > rowb)
      begin
        idx = 0;
        line = (line + 1) % 3;
      end
    end
    if (mon && pix.valid)
      check(pix.pixels, last_a[7:0] ^ last_a[15:8]);
    if (mon && pix.valid)
      check(pix.block, 1'b0);
  end

  initial
  begin
    #40000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hdf67));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (roff[i])
    begin
      apb(1'b0, roff[i], 32'h0);
      check(rd, rexp[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    rowb = 2 + $urandom % 3;
    total = rowb + 1 + $urandom % 3;
    pitch = 16 + $urandom % 16;
    h = 3'($urandom);
    apb(1'b1, lsc_pkg::OFF_ROWB, rowb);
    apb(1'b1, lsc_pkg::OFF_TOTAL, total);
    apb(1'b1, lsc_pkg::OFF_PITCH, pitch);
    apb(1'b1, lsc_pkg::OFF_LINES, 32'h2);
    apb(1'b1, lsc_pkg::OFF_SCROLL_START_ADDRESS_1, 32'h0100);
    apb(1'b1, lsc_pkg::OFF_HDOT, h);
    // generator base at the external window, bit6 option left clear
    apb(1'b1, lsc_pkg::OFF_CGBASE, 32'hf000);
    apb(1'b0, lsc_pkg::OFF_CGBASE, 32'h0);
    check(rd, 32'hf000);
    mon = 1'b1;
    apb(1'b1, lsc_pkg::OFF_CTRL, 32'h103);
    check(hdot, h);
    check(layer, 2'h1);
    // host traffic lands only in the line pause
    apb(1'b1, lsc_pkg::OFF_CURSOR, 32'h0200);
    apb(1'b1, lsc_pkg::OFF_STEP, 32'h2);
    apb(1'b1, lsc_pkg::OFF_MEMW, 32'ha5);
    wait_idle();
    apb(1'b1, lsc_pkg::OFF_MEMW, 32'h3c);
    wait_idle();
    check(mm.mem[16'h0200], 8'ha5);
    check(mm.mem[16'h0202], 8'h3c);
    apb(1'b1, lsc_pkg::OFF_MEMR, 32'h0);
    wait_idle();
    apb(1'b0, lsc_pkg::OFF_MEMR, 32'h0);
    check(rd, 32'h06);
    // blank the first byte of the line that a scroll would expose below the frame
    apb(1'b1, lsc_pkg::OFF_CURSOR, 32'h0100 + 3 * pitch);
    apb(1'b1, lsc_pkg::OFF_MEMW, 32'h00);
    wait_idle();
    check(mm.mem[16'h0100 + 3 * pitch], 8'h00);
    repeat (600) @(posedge clk);
    conclude();
  end
endmodule // lsc_scan_tb
